/* File: core/adc_compute_params.svh */
`ifndef ADC_COMPUTE_PARAMS_SVH
`define ADC_COMPUTE_PARAMS_SVH
// ****************************************
// register offsets (byte addresses)
// ****************************************
`define OFS_CTRL        8'h00
`define OFS_CFG         8'h04
`define OFS_RESULT      8'h08
`define OFS_ACC         8'h0c
`define OFS_COUNT       8'h10
`define OFS_FILTER      8'h14
`define OFS_PREV        8'h18
`define OFS_THRESH      8'h1c
`define OFS_IRQ_STAT    8'h20
`define OFS_IRQ_MASK    8'h24
`define OFS_ID          8'h28
// ****************************************
// field positions
// ****************************************
`define CTRL_GO_BIT     0
`define CFG_MODE_LSB    0
`define CFG_CLR_BIT     3
`define CFG_SHIFT_LSB   4
`define CFG_PSRC_BIT    7
`define IRQ_THR_BIT     0
`define IRQ_DONE_BIT    1
`define IRQ_OVF_BIT     2
// ****************************************
// reset values and limits
// ****************************************
`define CFG_RST         8'h00
`define THRESH_RST      16'hffff
`define IRQ_MASK_RST    3'h0
`define SHIFT_MAX       3'h5
`define DEVICE_ID_VAL   32'h0000_a5c1
// ****************************************
// timing: 11 converter clocks plus 3 instruction cycles
// ****************************************
`define CONV_CLK_PERIODS   11
`define INSTR_CYCLES       3
`define CONV_CLK_NS        1000
`define INSTR_CYCLE_NS     40
`define CLK_SYS_NS         10
`define CONV_CYCLES  ((`CONV_CLK_PERIODS*`CONV_CLK_NS + `INSTR_CYCLES*`INSTR_CYCLE_NS \
                      + `CLK_SYS_NS - 1) / `CLK_SYS_NS)
`endif

/* File: core/adc_compute_pkg.sv */
package adc_compute_pkg;
  // operating modes of the computation stage
  typedef enum logic [2:0] {
    MODE_BASIC   = 3'b000,
    MODE_ACCUM   = 3'b001,
    MODE_AVERAGE = 3'b010,
    MODE_BURST   = 3'b011,
    MODE_LOWPASS = 3'b100
  } compute_mode_t;

  // conversion sequencer states
  typedef enum logic [1:0] {
    ST_IDLE    = 2'b00,
    ST_CONVERT = 2'b01,
    ST_COMPUTE = 2'b10
  } seq_state_t;

  // register bus request
  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } reg_req_t;

  // result word from the converter core
  typedef struct packed {
    logic        valid;
    logic [9:0]  data;
  } conv_result_t;
endpackage

/* File: core/adc_result_computation.sv */
`include "adc_compute_params.svh"

module adc_result_computation
  import adc_compute_pkg::*;
(
  input  wire logic         clk_sys,
  input  wire logic         rst,
  input  wire logic [7:0]   reg_addr,
  input  wire logic [31:0]  reg_wdata,
  input  wire logic         reg_wr,
  input  wire logic         reg_rd,
  output logic      [31:0]  reg_rdata,
  input  wire logic [9:0]   conv_data,
  input  wire logic         conv_valid,
  output logic              conv_start,
  output logic              irq
);

  // ****************************************
  // bus request bundle
  // ****************************************
  reg_req_t     req;
  conv_result_t res_in;
  assign req    = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};
  assign res_in = '{valid: conv_valid, data: conv_data};

  // write decode shared by every register
  function automatic logic wr_hit(input reg_req_t r, input logic [7:0] ofs);
    wr_hit = r.wr && (r.addr == ofs);
  endfunction

  localparam logic [15:0] CONV_CNT = 16'(`CONV_CYCLES);

  // ****************************************
  // state
  // ****************************************
  seq_state_t   state_r,     state_nxt;
  logic         go_r,        go_nxt;
  logic [7:0]   cfg_r,       cfg_nxt;
  logic [15:0]  timer_r,     timer_nxt;
  logic [9:0]   result_r,    result_nxt;
  logic [17:0]  acc_r,       acc_nxt;
  logic         ovf_r,       ovf_nxt;
  logic [7:0]   count_r,     count_nxt;
  logic [15:0]  filter_r,    filter_nxt;
  logic [15:0]  prev_r,      prev_nxt;
  logic [15:0]  thresh_r,    thresh_nxt;
  logic [2:0]   irq_stat_r,  irq_stat_nxt;
  logic [2:0]   irq_mask_r,  irq_mask_nxt;
  logic [31:0]  rdata_r,     rdata_nxt;
  logic         start_r,     start_nxt;

  compute_mode_t mode;
  logic [2:0]    shift_sel;
  logic [18:0]   acc_sum;
  logic [2:0]    irq_set;
  logic [15:0]   shifted;

  assign mode      = compute_mode_t'(cfg_r[`CFG_MODE_LSB +: 3]);
  assign shift_sel = cfg_r[`CFG_SHIFT_LSB +: 3];
  assign acc_sum   = {1'b0, acc_r} + {9'h000, result_r};
  // stored accumulator, shifted: threshold value for mode codes above MODE_LOWPASS
  assign shifted   = 16'(acc_r >> shift_sel);

  // ****************************************
  // next-state computation
  // ****************************************
  always_comb
  begin
    state_nxt    = state_r;
    go_nxt       = go_r;
    cfg_nxt      = cfg_r;
    timer_nxt    = timer_r;
    result_nxt   = result_r;
    acc_nxt      = acc_r;
    ovf_nxt      = ovf_r;
    count_nxt    = count_r;
    filter_nxt   = filter_r;
    prev_nxt     = prev_r;
    thresh_nxt   = thresh_r;
    irq_mask_nxt = irq_mask_r;
    irq_set      = 3'h0;
    start_nxt    = 1'b0;
    // software writes
    if (wr_hit(req, `OFS_CFG))
    begin
      cfg_nxt = req.wdata[7:0];
    end
    if (wr_hit(req, `OFS_THRESH))
    begin
      thresh_nxt = req.wdata[15:0];
    end
    if (wr_hit(req, `OFS_IRQ_MASK))
    begin
      irq_mask_nxt = req.wdata[2:0];
    end
    // clear command acts in one cycle then drops itself
    if (cfg_r[`CFG_CLR_BIT])
    begin
      acc_nxt                = 18'h00000;
      ovf_nxt                = 1'b0;
      count_nxt              = 8'h00;
      cfg_nxt[`CFG_CLR_BIT]  = wr_hit(req, `OFS_CFG) && req.wdata[`CFG_CLR_BIT];
    end
    // conversion sequencer
    unique case (state_r)
      ST_IDLE:
      begin
        if (wr_hit(req, `OFS_CTRL) && req.wdata[`CTRL_GO_BIT])
        begin
          go_nxt    = 1'b1;
          start_nxt = 1'b1;
          timer_nxt = CONV_CNT - 16'h0002;
          prev_nxt  = cfg_r[`CFG_PSRC_BIT] ? filter_r : {6'h00, result_r};
          state_nxt = ST_CONVERT;
        end
      end
      ST_CONVERT:
      begin
        if (res_in.valid)
        begin
          result_nxt = res_in.data;
        end
        if (timer_r == 16'h0000)
        begin
          state_nxt = ST_COMPUTE;
        end
        else
        begin
          timer_nxt = timer_r - 16'h0001;
        end
      end
      ST_COMPUTE:
      begin
        if (mode != MODE_BASIC && mode <= MODE_LOWPASS)
        begin
          acc_nxt = acc_sum[17:0];
          if (acc_sum[18])
          begin
            ovf_nxt    = 1'b1;
            irq_set[`IRQ_OVF_BIT] = 1'b1;
          end
          count_nxt  = (count_r == 8'hff) ? count_r : count_r + 8'h01;
          // filter takes the accumulator including this sample, low bits dropped
          filter_nxt = 16'(acc_sum[17:0] >> shift_sel);
        end
        // threshold runs in every mode, basic included
        if ((mode == MODE_BASIC) ? ({6'h00, result_r} > thresh_r) :
            (mode <= MODE_LOWPASS) ? (16'(acc_sum[17:0] >> shift_sel) > thresh_r) :
            (shifted > thresh_r))
        begin
          irq_set[`IRQ_THR_BIT] = 1'b1;
        end
        irq_set[`IRQ_DONE_BIT] = 1'b1;
        go_nxt    = 1'b0;
        state_nxt = ST_IDLE;
      end
      default:
      begin
        state_nxt = ST_IDLE;
      end
    endcase
    // status: hardware set wins over write-one-to-clear
    irq_stat_nxt = irq_stat_r;
    if (wr_hit(req, `OFS_IRQ_STAT))
    begin
      irq_stat_nxt = irq_stat_r & ~req.wdata[2:0];
    end
    irq_stat_nxt = irq_stat_nxt | irq_set;
    // read data one cycle after the strobe
    rdata_nxt = 32'h00000000;
    if (req.rd)
    begin
      unique case (req.addr)
        `OFS_CTRL:     rdata_nxt = {31'h0, go_r};
        `OFS_CFG:      rdata_nxt = {24'h0, cfg_r};
        `OFS_RESULT:   rdata_nxt = {22'h0, result_r};
        `OFS_ACC:      rdata_nxt = {13'h0, ovf_r, acc_r};
        `OFS_COUNT:    rdata_nxt = {24'h0, count_r};
        `OFS_FILTER:   rdata_nxt = {16'h0, filter_r};
        `OFS_PREV:     rdata_nxt = {16'h0, prev_r};
        `OFS_THRESH:   rdata_nxt = {16'h0, thresh_r};
        `OFS_IRQ_STAT: rdata_nxt = {29'h0, irq_stat_r};
        `OFS_IRQ_MASK: rdata_nxt = {29'h0, irq_mask_r};
        `OFS_ID:       rdata_nxt = `DEVICE_ID_VAL; // arbitrary identification value
        default:       rdata_nxt = 32'h00000000;
      endcase
    end
  end

  // ****************************************
  // registers
  // ****************************************
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      state_r    <= ST_IDLE;
      go_r       <= 1'b0;
      cfg_r      <= `CFG_RST;
      timer_r    <= 16'h0000;
      result_r   <= 10'h000;
      acc_r      <= 18'h00000;
      ovf_r      <= 1'b0;
      count_r    <= 8'h00;
      filter_r   <= 16'h0000;
      prev_r     <= 16'h0000;
      thresh_r   <= `THRESH_RST;
      irq_stat_r <= 3'h0;
      irq_mask_r <= `IRQ_MASK_RST;
      rdata_r    <= 32'h00000000;
      start_r    <= 1'b0;
    end
    else
    begin
      state_r    <= state_nxt;
      go_r       <= go_nxt;
      cfg_r      <= cfg_nxt;
      timer_r    <= timer_nxt;
      result_r   <= result_nxt;
      acc_r      <= acc_nxt;
      ovf_r      <= ovf_nxt;
      count_r    <= count_nxt;
      filter_r   <= filter_nxt;
      prev_r     <= prev_nxt;
      thresh_r   <= thresh_nxt;
      irq_stat_r <= irq_stat_nxt;
      irq_mask_r <= irq_mask_nxt;
      rdata_r    <= rdata_nxt;
      start_r    <= start_nxt;
    end
  end

  // outputs
  assign reg_rdata  = rdata_r;
  assign conv_start = start_r;
  assign irq        = |(irq_stat_r & irq_mask_r);

endmodule // adc_result_computation

/* File: tb/adc_compute_checker.sv */
// ****
// port checks
// ****
module adc_compute_checker (
  input wire logic        clk_sys,
  input wire logic        rst,
  input wire logic [7:0]  reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic [9:0]  conv_data,
  input wire logic        conv_valid,
  input wire logic        conv_start,
  input wire logic        irq
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking dc @(posedge clk_sys); endclocking
  default disable iff (rst);
  // bus steps
  sequence go_wr; reg_wr && reg_addr == 8'h00 && reg_wdata[0]; endsequence
  sequence go_rd; reg_rd && reg_addr == 8'h00; endsequence
  sequence clr_wr; reg_wr && reg_addr == 8'h04 && reg_wdata[3]; endsequence
  sequence cfg_wr; reg_wr && reg_addr == 8'h04; endsequence
  sequence cfg_rd; reg_rd && reg_addr == 8'h04; endsequence
  sequence cnt_rd; reg_rd && reg_addr == 8'h10; endsequence
  rdata_idle_a: assert property (!reg_rd |=> reg_rdata == 32'h0)
    else $error("read data outside read cycle");
  start_cause_a: assert property (conv_start |-> $past(reg_wr) && $past(reg_addr) == 8'h00)
    else $error("start without go write");
  start_pulse_a: assert property (conv_start |=> !conv_start)
    else $error("start longer than one cycle");
  go_refused_a: assert property (conv_start ##1 go_wr |=> !conv_start [*8])
    else $error("go accepted while busy");
  go_busy_a: assert property (go_wr ##1 conv_start ##[1:1000] go_rd |=> reg_rdata[0])
    else $error("go cleared too early");
  mask_off_a: assert property (reg_wr && reg_addr == 8'h24 && reg_wdata[2:0] == 3'h0 |=> !irq)
    else $error("irq with mask zero");
  mode_echo_a: assert property (cfg_wr ##2 cfg_rd |=> reg_rdata[2:0] == $past(reg_wdata[2:0], 3))
    else $error("mode field not held");
  clear_cnt_a: assert property (clr_wr ##6 cnt_rd |=> reg_rdata[7:0] == 8'h0)
    else $error("counter not cleared");
endmodule // adc_compute_checker

bind adc_result_computation adc_compute_checker chk (.clk_sys(clk_sys), .rst(rst),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .conv_data(conv_data), .conv_valid(conv_valid),
  .conv_start(conv_start), .irq(irq));

/* File: tb/conv_core_model.sv */
// ****
// converter core stand-in
// ****
module conv_core_model (
  input  wire logic       clk_sys,
  input  wire logic       rst,
  input  wire logic       conv_start,
  input  wire logic [9:0] sample,
  input  wire logic [9:0] lag,
  output logic      [9:0] conv_data,
  output logic            conv_valid
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [10:0] left_r;
  // answers once, lag cycles after start; data scrambles outside that cycle
  always @(posedge clk_sys)
  begin
    conv_valid <= !rst && left_r == 11'h1;
    conv_data  <= rst ? 10'h155 : (left_r == 11'h1) ? sample : ~conv_data;
    left_r     <= rst ? 11'h0 : conv_start ? {1'b0, lag} : (left_r != 11'h0) ? left_r - 11'h1 : 11'h0;
  end
endmodule // conv_core_model

/* File: tb/test_adc_result_computation.sv */
`include "adc_compute_params.svh"
// ****
// bench top
// ****
module test_adc_result_computation;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk_sys = 1'b0;
  logic        rst = 1'b1;
  logic [7:0]  reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic        rd_pend = 1'b0;
  logic [9:0]  sample = 10'h0;
  logic [9:0]  lag = 10'h1;
  logic [31:0] reg_rdata;
  logic [9:0]  conv_data;
  logic        conv_valid;
  logic        conv_start;
  logic        irq;
  logic [63:0] ent;
  logic [31:0] last_rd = 32'h0;
  logic [63:0] exp_q[$];
  int          num_errors = 0;
  int          compares = 0;
  int          cyc = 0;
  int          seed = 32'hc7b4;
  adc_result_computation DUT (.clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .conv_data(conv_data), .conv_valid(conv_valid), .conv_start(conv_start), .irq(irq));
  conv_core_model core (.clk_sys(clk_sys), .rst(rst), .conv_start(conv_start),
    .sample(sample), .lag(lag), .conv_data(conv_data), .conv_valid(conv_valid));
  always #5 clk_sys = ~clk_sys;
  // tasks for compare, bus cycles and one conversion
  task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e)
    begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    @(posedge clk_sys);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
    exp_q.push_back({m, e});
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    @(posedge clk_sys);
  endtask
  task automatic run_conv(input logic [9:0] v);
    int   n;
    logic busy;
    sample <= v;
    lag <= 10'($random(seed)) | 10'h1;
    wr(`OFS_CTRL, 32'h1);
    wr(`OFS_CTRL, 32'h1);
    n = 1;
    busy = 1'b1;
    while (busy !== 1'b0 && n < 3000)
    begin
      rd(`OFS_CTRL, 32'h0, 32'h0);
      busy = last_rd[0];
      n += 2;
    end
    chk("conv time", 32'h1, 32'(n > `CONV_CYCLES && n < `CONV_CYCLES + 5));
  endtask
  task automatic complete_run;
    $display("compares %0d mismatches %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // read data checker and hang guard
  always @(posedge clk_sys)
  begin
    rd_pend <= reg_rd;
    cyc++;
    if (cyc == 30000)
    begin
      num_errors++;
      complete_run;
    end
  end
  always @(negedge clk_sys)
    if (rd_pend)
    begin
      ent = exp_q.pop_front();
      last_rd = reg_rdata;
      if (ent[63:32] !== 32'h0)
        chk("rdata", ent[31:0] & ent[63:32], reg_rdata & ent[63:32]);
    end
  // main sequence: reset values, then mode codes 0 to 5
  initial
  begin
    int          m;
    logic        acc;
    logic [9:0]  v1;
    logic [9:0]  v2;
    logic [7:0]  cfg;
    logic [31:0] sum;
    repeat (2) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    rd(`OFS_THRESH, 32'hffff, 32'hffff);
    rd(`OFS_IRQ_MASK, 32'h0, 32'h7);
    rd(`OFS_CFG, 32'h0, 32'hff);
    rd(8'h2c, 32'h0, 32'hffffffff);
    wr(`OFS_THRESH, 32'h0);
    for (m = 0; m < 6; m++)
    begin
      v1 = 10'($random(seed)) | 10'h200;
      v2 = 10'($random(seed)) | 10'h200;
      acc = m >= 1 && m <= 4;
      cfg = {m[0], m[2:0], 1'b0, m[2:0]};
      wr(`OFS_IRQ_MASK, (m == 2) ? 32'h0 : 32'h7);
      wr(`OFS_CFG, cfg | 8'h08);
      wr(`OFS_CFG, cfg);
      rd(`OFS_CFG, cfg, 32'hff);
      rd(`OFS_COUNT, 32'h0, 32'hff);
      run_conv(v1);
      run_conv(v2);
      sum = acc ? v1 + v2 : 32'h0;
      rd(`OFS_RESULT, v2, 32'h3ff);
      rd(`OFS_ACC, sum, 32'h7ffff);
      rd(`OFS_COUNT, acc ? 32'h2 : 32'h0, 32'hff);
      rd(`OFS_FILTER, sum >> m, acc ? 32'hffff : 32'h0);
      rd(`OFS_PREV, m[0] ? v1 >> m : v1, (m == 5) ? 32'h0 : 32'hffff);
      rd(`OFS_IRQ_STAT, (m != 5) ? 32'h3 : 32'h2, 32'h3);
      @(negedge clk_sys);
      chk("irq", 32'(m != 2), 32'(irq));
      @(posedge clk_sys);
      wr(`OFS_IRQ_STAT, 32'h7);
      @(negedge clk_sys);
      chk("irq clear", 32'h0, 32'(irq));
      @(posedge clk_sys);
      $display("test mode %0d done", m);
    end
    complete_run;
  end
endmodule // test_adc_result_computation
